// ---- shared/tcwm_pkg.sv ----
// Constants and types shared by the 8-bit compare and waveform timer
`default_nettype none

package tcwm_pkg;

	// Register indices on the plain register port
	localparam logic [2:0] TCWM_CTRL_IDX  = 3'h0;
	localparam logic [2:0] TCWM_COUNT_IDX = 3'h1;
	localparam logic [2:0] TCWM_CMP_IDX   = 3'h2;
	localparam logic [2:0] TCWM_FLAG_IDX  = 3'h3;

	// Flag register bit positions (write one to clear)
	localparam int TCWM_OVF_BIT = 0;
	localparam int TCWM_CMF_BIT = 1;

	// Reset values
	localparam logic [7:0] TCWM_CTRL_RST  = 8'h00;
	localparam logic [7:0] TCWM_COUNT_RST = 8'h00;
	localparam logic [7:0] TCWM_CMP_RST   = 8'h00;
	localparam logic       TCWM_OC_RST    = 1'h0;

	// Count extremes
	localparam logic [7:0] TCWM_BOTTOM = 8'h00;
	localparam logic [7:0] TCWM_MAX    = 8'hFF;

	// Timer clock enable dividers, terminal counts of the prescale counter
	localparam logic [5:0] TCWM_DIV8_END  = 6'h07;
	localparam logic [5:0] TCWM_DIV64_END = 6'h3F;

	// Counting modes, in field order
	typedef enum logic [1:0] {
		TCWM_NORMAL, TCWM_PC_PWM, TCWM_CLEAR_ON_MATCH, TCWM_FAST_PWM
	} tcwm_mode_t;

	// Output actions, in field order
	typedef enum logic [1:0] {
		TCWM_ACT_NONE, TCWM_ACT_TOGGLE, TCWM_ACT_CLEAR, TCWM_ACT_SET
	} tcwm_action_t;

	// Clock select: stopped, every clk, clk/8, clk/64
	typedef enum logic [1:0] {
		TCWM_CLK_STOP, TCWM_CLK_DIV1, TCWM_CLK_DIV8, TCWM_CLK_DIV64
	} tcwm_clksel_t;

	// Control register layout
	typedef struct packed {
		logic         forceCompareStrobe;
		logic         reserved;
		tcwm_action_t outputActionField;
		tcwm_clksel_t clockSelect;
		tcwm_mode_t   waveformModeField;
	} tcwm_ctrl_t;

endpackage : tcwm_pkg

`default_nettype wire

// ---- rtl/tcwm_timer.sv ----
// 8-bit timer with compare match output, force strobe and mode sequencing
//
// How it works
// - Counter write blocks next timer-cycle match
// - Output state survives waveform mode changes
// - Action field unbuffered, used at next match
// - Reset clears compare output state
// - Nonzero action field routes state to pin
// - Pin override ignores waveform mode
// - Action zero leaves output state alone
// - Force strobe applies action in non-PWM
// - Only mode field shapes counting
// - Action means polarity in PWM, else set/clear/toggle
// - Normal mode increments, wraps FF to 00
// - Normal overflow flag set on reaching zero
// - Normal mode accepts counter writes anytime
// - Clear-on-match clears counter at compare
// - Clear-on-match compare updates immediately
// - Clear-on-match toggle action toggles each match
// - Clear-on-match overflow on MAX to zero
// - Fast PWM counts bottom to MAX, clears
// - Fast PWM: match and bottom drive polarity
// - Fast PWM overflow flag at MAX
// - Comparator match sets compare flag
// - Counter write beats clear and count
// - Force neither flags nor clears counter
// - Non-PWM actions 1,2,3 toggle, clear, set
`default_nettype none

module tcwm_timer
	import tcwm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	input  wire logic       portData,
	input  wire logic       outputPinDirectionBit,
	output logic            pinOut,
	output logic            pinOe,
	output logic            compareOutputState,
	output logic            overflowFlag,
	output logic            compareFlag
);

	////////////////////////////////////////////////////////////////////////////
	// State

	tcwm_ctrl_t  ctrl;            // Control, strobe bit always stored as zero
	logic  [7:0] counterValue;    // Running count
	logic  [7:0] compareValue;    // Compare value the comparator sees
	logic  [7:0] compareBuffer;   // Last compare value written by software
	logic        blockMatch;      // Set by a counter write until next tick
	logic  [5:0] prescale;        // Free-running divider for the tick
	logic        next_ocState;    // Next compare output state
	logic  [7:0] next_count;      // Next counter value on a tick

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Set, clear or toggle as non-PWM compare action
	function automatic logic applyAction(input tcwm_action_t act, input logic oc);
		unique case (act)
			TCWM_ACT_TOGGLE: applyAction = !oc;
			TCWM_ACT_CLEAR:  applyAction = 1'h0;
			TCWM_ACT_SET:    applyAction = 1'h1;
			TCWM_ACT_NONE:   applyAction = oc;
		endcase
	endfunction : applyAction

	// Register select for writes and reads
	function automatic logic hitReg(input logic [2:0] a, input logic [2:0] idx);
		hitReg = (a == idx);
	endfunction : hitReg

	////////////////////////////////////////////////////////////////////////////
	// Decode

	wire tcwm_ctrl_t wrCtrlVal = tcwm_ctrl_t'(regWdata);    // Control as written
	wire wrCtrl  = regWr && hitReg(regAddr, TCWM_CTRL_IDX);
	wire wrCount = regWr && hitReg(regAddr, TCWM_COUNT_IDX);
	wire wrCmp   = regWr && hitReg(regAddr, TCWM_CMP_IDX);
	wire wrFlag  = regWr && hitReg(regAddr, TCWM_FLAG_IDX);

	// Both PWM codes keep low mode bit set; phase-correct runs as fast PWM here
	wire pwmMode = ctrl.waveformModeField[0];
	wire ctcMode = (ctrl.waveformModeField == TCWM_CLEAR_ON_MATCH);

	// Timer clock enable from the divider
	wire tick = (ctrl.clockSelect == TCWM_CLK_DIV1)
		|| ((ctrl.clockSelect == TCWM_CLK_DIV8) && (prescale[2:0] == TCWM_DIV8_END[2:0]))
		|| ((ctrl.clockSelect == TCWM_CLK_DIV64) && (prescale == TCWM_DIV64_END));

	// Comparator, gated by the post-write block
	wire matchHit = tick && !blockMatch && (counterValue == compareValue);
	wire atMax    = (counterValue == TCWM_MAX);
	// Leaving MAX: overflow in every mode, bottom event in PWM
	wire ovfTick    = tick && atMax;
	wire bottomTick = ovfTick && pwmMode;

	// Force only acts when the written mode is non-PWM
	wire forceHit = wrCtrl && wrCtrlVal.forceCompareStrobe
		&& !wrCtrlVal.waveformModeField[0];

	// Pin source follows the action field alone, never the mode
	wire overrideActive = |ctrl.outputActionField;

	////////////////////////////////////////////////////////////////////////////
	// Pin mux; direction stays with the port's own bit

	assign pinOut = overrideActive ? compareOutputState : portData;
	assign pinOe  = outputPinDirectionBit;

	////////////////////////////////////////////////////////////////////////////
	// Next count; the mode field alone picks the sequence

	always_comb begin
		next_count = 8'(counterValue + 8'h01);
		// Clear at the match, compare value acting as top
		if (ctcMode && matchHit) begin
			next_count = TCWM_BOTTOM;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next output state; no mode switch touches it

	always_comb begin
		next_ocState = compareOutputState;
		if (forceHit) begin
			// Uses the action field just written with the strobe
			next_ocState = applyAction(wrCtrlVal.outputActionField,
				compareOutputState);
		end else if (pwmMode) begin
			// Polarity mode: match edge first, bottom edge wins ties
			if (matchHit) begin
				next_ocState = applyAction(ctrl.outputActionField, compareOutputState);
			end
			if (bottomTick && ctrl.outputActionField == TCWM_ACT_CLEAR) begin
				next_ocState = 1'h1;
			end
			if (bottomTick && ctrl.outputActionField == TCWM_ACT_SET) begin
				next_ocState = 1'h0;
			end
		end else if (matchHit) begin
			// Live field, no buffering; zero keeps the state
			next_ocState = applyAction(ctrl.outputActionField,
				compareOutputState);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Divider

	// Runs always; only the select decides whether a tick comes out
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescale <= 6'h00;
		end else begin
			prescale <= 6'(prescale + 6'h01);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register; the strobe is never stored so it reads zero

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= tcwm_ctrl_t'(TCWM_CTRL_RST);
		end else if (wrCtrl) begin
			ctrl <= '{forceCompareStrobe: 1'h0, reserved: 1'h0,
				outputActionField: wrCtrlVal.outputActionField,
				clockSelect: wrCtrlVal.clockSelect,
				waveformModeField: wrCtrlVal.waveformModeField};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter; software write wins over any tick

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			counterValue <= TCWM_COUNT_RST;
		end else if (wrCount) begin
			counterValue <= regWdata;
		end else if (tick) begin
			counterValue <= next_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Match block; holds even while stopped until a tick consumes it

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			blockMatch <= 1'h0;
		end else if (wrCount) begin
			blockMatch <= 1'h1;
		end else if (tick) begin
			blockMatch <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare value: direct in non-PWM, loaded at MAX in PWM

	// PWM loads at MAX so no pulse of odd length reaches the pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			compareBuffer <= TCWM_CMP_RST;
			compareValue  <= TCWM_CMP_RST;
		end else begin
			if (wrCmp) begin
				compareBuffer <= regWdata;
			end
			if (wrCmp && !pwmMode) begin
				compareValue <= regWdata;
			end else if (bottomTick) begin
				compareValue <= compareBuffer;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare output state

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			compareOutputState <= TCWM_OC_RST;
		end else begin
			compareOutputState <= next_ocState;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags; a set in the clearing cycle wins

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overflowFlag <= 1'h0;
			compareFlag  <= 1'h0;
		end else begin
			overflowFlag <= ovfTick
				|| (overflowFlag && !(wrFlag && regWdata[TCWM_OVF_BIT]));
			// Force is not in this term, so it never flags
			compareFlag <= matchHit
				|| (compareFlag && !(wrFlag && regWdata[TCWM_CMF_BIT]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port; data stand one cycle after the strobe, zero otherwise

	wire [7:0] flagByte = {6'h00, compareFlag, overflowFlag};
	wire [7:0] rdMux = hitReg(regAddr, TCWM_CTRL_IDX)  ? 8'(ctrl)
		: hitReg(regAddr, TCWM_COUNT_IDX) ? counterValue
		: hitReg(regAddr, TCWM_CMP_IDX)   ? compareBuffer
		: hitReg(regAddr, TCWM_FLAG_IDX)  ? flagByte
		: 8'h00;                                                     // Unmapped reads zero

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRd ? rdMux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence maxLeave;
		tick && atMax && !wrCount;
	endsequence

	sequence atBottomFlagged;
		(counterValue == TCWM_BOTTOM) && overflowFlag;
	endsequence

	block_after_write_a: assert property (
		wrCount ##1 (!wrCount && tick && counterValue == compareValue) |-> !matchHit
	) else $error("match not blocked after counter write");

	oc_mode_hold_a: assert property (
		wrCtrl && !forceHit && !matchHit && !bottomTick |=> $stable(compareOutputState)
	) else $error("output state changed on mode write");

	pin_override_a: assert property (
		pinOe == outputPinDirectionBit
		&& pinOut == (overrideActive ? compareOutputState : portData)
	) else $error("pin source or direction wrong");

	action_none_a: assert property (
		!pwmMode && matchHit && !forceHit && ctrl.outputActionField == TCWM_ACT_NONE
		|=> $stable(compareOutputState)
	) else $error("action none changed output state");

	force_set_a: assert property (
		forceHit && wrCtrlVal.outputActionField == TCWM_ACT_SET |=> compareOutputState
	) else $error("force set did not set output state");

	force_quiet_a: assert property (
		forceHit && !matchHit && !compareFlag && !wrCount && !tick
		|=> !compareFlag && $stable(counterValue)
	) else $error("force flagged or moved counter");

	normal_wrap_a: assert property (
		maxLeave and (ctrl.waveformModeField == TCWM_NORMAL) |=> atBottomFlagged
	) else $error("normal mode did not wrap with overflow");

	ctc_clear_a: assert property (
		ctcMode && matchHit && !wrCount |=> counterValue == TCWM_BOTTOM
	) else $error("clear-on-match did not clear");

	fast_top_a: assert property (
		maxLeave and pwmMode |=> atBottomFlagged
	) else $error("fast PWM did not flag at MAX");

	match_flag_a: assert property (
		matchHit |=> compareFlag
	) else $error("match did not set compare flag");

	write_prio_a: assert property (
		wrCount |=> counterValue == $past(regWdata)
	) else $error("counter write lost to count or clear");

	// Non-inverting PWM must come back high at every bottom
	pwm_bottom_a: assert property (
		bottomTick && !forceHit && ctrl.outputActionField == TCWM_ACT_CLEAR
		|=> compareOutputState
	) else $error("fast PWM bottom did not set output state");

	ctc_toggle_a: assert property (
		ctcMode && matchHit && !forceHit && ctrl.outputActionField == TCWM_ACT_TOGGLE
		|=> compareOutputState != $past(compareOutputState)
	) else $error("clear-on-match toggle missed");

	ctc_ovf_a: assert property (
		maxLeave and ctcMode |=> overflowFlag
	) else $error("clear-on-match did not flag overflow");

endmodule : tcwm_timer

`default_nettype wire

// ---- bench/tcwm_pin_model.sv ----
// Port pin pad model seen from the board side of the timer output
`default_nettype none

module tcwm_pin_model (
	input  wire logic clk,
	input  wire logic pinOut,
	input  wire logic pinOe,
	output logic      padLevel
);
	timeunit 1ns;
	timeprecision 100ps;

	logic floatLevel; // Undriven pad level, no pull resistor

	// An undriven pad wanders, so a stale value can never pass a check
	initial floatLevel = 1'b0;
	always @(posedge clk) begin
		floatLevel <= ~floatLevel;
	end

	// Pad shows the pin only while the direction bit enables the driver
	assign padLevel = pinOe ? pinOut : floatLevel;

endmodule : tcwm_pin_model

`default_nettype wire

// ---- bench/tcwm_timer_tb.sv ----
// Self-checking testbench for the compare and waveform timer
`default_nettype none

module tcwm_timer_tb
	import tcwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clk;                   // Bench clock, 4 ns
	logic       sys_rst;               // Async reset
	logic [2:0] regAddr;               // Register index
	logic [7:0] regWdata;              // Write data
	logic       regWr;                 // Write strobe
	logic       regRd;                 // Read strobe
	logic [7:0] regRdata;              // Read data
	logic       portData;              // General port data
	logic       outputPinDirectionBit; // Port direction
	logic       pinOut;                // Pin value
	logic       pinOe;                 // Pin driver enable
	logic       compareOutputState;    // Internal output state
	logic       overflowFlag;          // Overflow flag
	logic       compareFlag;           // Compare flag
	logic       padLevel;              // Level on the pad
	logic [7:0] rdv;                   // Last read value
	int         err_total;             // Mismatches
	int         num_checks;            // Comparisons

	////////////////////////////////////////////////////////////////
	tcwm_timer i_dut (
		.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portData(portData),
		.outputPinDirectionBit(outputPinDirectionBit), .pinOut(pinOut), .pinOe(pinOe),
		.compareOutputState(compareOutputState), .overflowFlag(overflowFlag),
		.compareFlag(compareFlag)
	);
	tcwm_pin_model i_pad (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));

	////////////////////////////////////////////////////////////////
	// Clock generator
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Compare and report
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic check1(input logic seen, input logic exp);
		check({7'h00, seen}, {7'h00, exp});
	endtask : check1

	// Strobes are left up so writes may run back to back
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regRd <= 1'b0;
		regWr <= 1'b1;
		@(posedge clk);
	endtask : wr

	task automatic idle(input int n);
		regWr <= 1'b0;
		regRd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		regAddr <= a;
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask : rd

	// Let the last edge's updates land
	task automatic settle();
		idle(1);
		#1;
	endtask : settle

	task automatic cnt(input logic [7:0] exp);
		rd(TCWM_COUNT_IDX, rdv);
		check(rdv, exp);
	endtask : cnt

	function automatic logic [7:0] ctl(input logic f, input logic [1:0] a,
		input logic [1:0] c, input logic [1:0] m);
		return {f, 1'b0, a, c, m};
	endfunction : ctl

	// Exactly n clock edges with the select on (n ticks only at clk/1): start edge excluded, stop edge included
	task automatic run(input logic [7:0] c, input int n);
		wr(TCWM_CTRL_IDX, c);
		if (n > 1) idle(n - 1);
		wr(TCWM_CTRL_IDX, c & 8'hF3);
		settle();
	endtask : run

	task automatic close_out();
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the roughly 700 cycles of the sequence
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		close_out();
	end

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		regAddr = 3'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		portData = 1'b1;
		outputPinDirectionBit = 1'b0;
		err_total = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		check1(compareOutputState, 1'b0);
		check({6'h00, overflowFlag, compareFlag}, 8'h00);
		check1(pinOut, 1'b1);
		// Force each action with the driver still off: set, clear, toggle, none
		for (int a = 3; a >= 0; a--) begin
			wr(TCWM_CTRL_IDX, ctl(1'b1, a[1:0], TCWM_CLK_STOP, TCWM_NORMAL));
			settle();
			check1(compareOutputState, 1'(4'hB >> a));
			check1(compareFlag, 1'b0);
		end
		cnt(8'h00);
		portData <= 1'b0;
		outputPinDirectionBit <= 1'b1;
		settle();
		check({6'h00, pinOe, pinOut}, 8'h02);
		check1(padLevel, 1'b0);
		// Override follows the action field whatever the mode
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_SET, TCWM_CLK_STOP, TCWM_CLEAR_ON_MATCH));
		settle();
		check({6'h00, compareOutputState, padLevel}, 8'h03);
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_SET, TCWM_CLK_STOP, TCWM_FAST_PWM));
		settle();
		check({6'h00, compareOutputState, pinOut}, 8'h03);
		rd(3'h5, rdv);
		check(rdv, 8'h00);
		// Counter write blocks the next match, timer stopped at the time
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_STOP, TCWM_NORMAL));
		wr(TCWM_CMP_IDX, 8'h05);
		wr(TCWM_COUNT_IDX, 8'h05);
		run(ctl(1'b0, TCWM_ACT_TOGGLE, TCWM_CLK_DIV1, TCWM_NORMAL), 1);
		check({6'h00, compareOutputState, compareFlag}, 8'h02);
		cnt(8'h06);
		// Counter write on a tick edge wins over the count
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV1, TCWM_NORMAL));
		wr(TCWM_COUNT_IDX, 8'h40);
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_STOP, TCWM_NORMAL));
		settle();
		cnt(8'h41);
		// Write equal to compare while running: the very next tick must not match
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV1, TCWM_NORMAL));
		wr(TCWM_COUNT_IDX, 8'h05);
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_STOP, TCWM_NORMAL));
		settle();
		check1(compareFlag, 1'b0);
		cnt(8'h06);
		// Any 16 edges hold two clk/8 ticks, any 64 edges one clk/64 tick
		run(ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV8, TCWM_NORMAL), 16);
		cnt(8'h08);
		run(ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV64, TCWM_NORMAL), 64);
		cnt(8'h09);
		// Normal mode wrap
		wr(TCWM_COUNT_IDX, 8'hFD);
		wr(TCWM_FLAG_IDX, 8'h03);
		run(ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV1, TCWM_NORMAL), 3);
		check1(overflowFlag, 1'b1);
		cnt(8'h00);
		// Clear on match with toggle, then with no action
		wr(TCWM_FLAG_IDX, 8'h03);
		wr(TCWM_CMP_IDX, 8'h03);
		run(ctl(1'b0, TCWM_ACT_TOGGLE, TCWM_CLK_DIV1, TCWM_CLEAR_ON_MATCH), 4);
		check({6'h00, compareOutputState, compareFlag}, 8'h01);
		check1(overflowFlag, 1'b0);
		cnt(8'h00);
		wr(TCWM_FLAG_IDX, 8'h03);
		run(ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV1, TCWM_CLEAR_ON_MATCH), 4);
		check({6'h00, compareOutputState, compareFlag}, 8'h01);
		cnt(8'h00);
		// Count already past the compare runs through MAX first
		wr(TCWM_FLAG_IDX, 8'h03);
		wr(TCWM_COUNT_IDX, 8'h05);
		run(ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_DIV1, TCWM_CLEAR_ON_MATCH), 251);
		check({6'h00, overflowFlag, compareFlag}, 8'h02);
		cnt(8'h00);
		// Fast PWM, non-inverting: clear at match, set at bottom
		wr(TCWM_CTRL_IDX, ctl(1'b0, TCWM_ACT_NONE, TCWM_CLK_STOP, TCWM_NORMAL));
		wr(TCWM_CMP_IDX, 8'h02);
		wr(TCWM_FLAG_IDX, 8'h03);
		wr(TCWM_CTRL_IDX, ctl(1'b1, TCWM_ACT_SET, TCWM_CLK_STOP, TCWM_NORMAL));
		run(ctl(1'b0, TCWM_ACT_CLEAR, TCWM_CLK_DIV1, TCWM_FAST_PWM), 3);
		check({6'h00, compareOutputState, compareFlag}, 8'h01);
		check1(overflowFlag, 1'b0);
		cnt(8'h03);
		run(ctl(1'b0, TCWM_ACT_CLEAR, TCWM_CLK_DIV1, TCWM_FAST_PWM), 253);
		check({6'h00, compareOutputState, overflowFlag}, 8'h03);
		cnt(8'h00);
		close_out();
	end

endmodule : tcwm_timer_tb

`default_nettype wire
